// *** src/pseudo_random_sequence_gen_mon_pkg.sv ***
// package for the payload test-sequence generator and monitor
// assumes one system byte clock; register port is a plain strobe port
package pseudo_random_sequence_gen_mon_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL     = 4'h0;
    localparam logic [3:0] ADDR_STATUS   = 4'h1;
    localparam logic [3:0] ADDR_INT_STAT = 4'h2;
    localparam logic [3:0] ADDR_INT_MASK = 4'h3;
    localparam logic [3:0] ADDR_ERR_CNT  = 4'h4;

    // ----------------------------------------------------------------
    // control fields
    // ----------------------------------------------------------------
    localparam int CTRL_GEN_EN     = 0;
    localparam int CTRL_MON_EN     = 1;
    localparam int CTRL_OWN_FRAME  = 2;
    localparam int CTRL_MASTER     = 3;
    localparam int CTRL_SLAVE      = 4;
    localparam int CTRL_RESTART    = 5;
    localparam int CTRL_TYPE_LSB   = 6;
    localparam int CTRL_ERR_CLR    = 8;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
    localparam logic [31:0] INT_MASK_RESET = 32'h0000_0000;

    // interrupt status bits
    localparam int INT_LOCK_CHG = 0;
    localparam int INT_OOS      = 1;

    // status bits
    localparam int ST_LOCKED  = 0;
    localparam int ST_GEN_OOS = 1;
    localparam int ST_MON_OOS = 2;

    // ----------------------------------------------------------------
    // sequence and lock figures
    // ----------------------------------------------------------------
    localparam int           PSEUDO_RANDOM_SEQUENCE_LEN    = 23;
    localparam int           PSEUDO_RANDOM_SEQUENCE_TAP    = 18;
    localparam logic [22:0]  PSEUDO_RANDOM_SEQUENCE_SEED   = 23'h7F_FFFF;
    localparam int           LOCK_GOOD   = 32;
    localparam int           LOSS_BAD    = 16;
    localparam int           COL_CNT_W   = 8;

    // payload types
    typedef enum logic [1:0]
    {
        PL_STS1,
        PL_STS3C,
        PL_STS12C,
        PL_STS48C
    } payload_t;

    // one byte lane of the add/drop bus with its markers
    typedef struct packed
    {
        logic [7:0] data;
        logic       frame;
        logic       payload;
        logic       poh;
    } bus_byte_t;

endpackage

// *** src/pseudo_random_sequence_gen_mon.sv ***
// payload test-sequence generator and monitor, one quarter of an STS-48c
// assumes add/drop bus bytes synchronous to clk_sys_in, frame aligned
`timescale 1ns/1ns

// Overview of operation
// - generate and separately check an unframed 2^23-1 sequence in payload
// - sequence placed in STS-1, STS-3c, STS-12c or STS-48c payloads
// - skip path overhead and fixed-stuff columns per payload type
// - choose: keep incoming framing, or make framing ourselves
// - STS-48c: master plus three slaves, each making a quarter
// - master broadcasts signature; slave flags out-of-step on mismatch
// - realign only on software restart at the master; slaves never self-align
// - lock after 32 consecutive matching payload bytes
// - count pattern errors only while locked
// - lose lock after 16 consecutive mismatches, then keep reacquiring
// - STS-48c checkers each check a quarter, slaves verify by signature
// - any lock change sets a maskable interrupt
module pseudo_random_sequence_gen_mon
    import pseudo_random_sequence_gen_mon_pkg::*;
#(
    parameter int ERR_W = 16
)
(
    input  wire logic                         clk_sys_in,
    input  wire logic                         rst_b_in,
    input  wire logic [3:0]                   reg_addr_in,
    input  wire logic [31:0]                  reg_wdata_in,
    input  wire logic                         reg_wr_in,
    input  wire logic                         reg_rd_in,
    output logic [31:0]                       reg_rdata_out,
    input  wire pseudo_random_sequence_gen_mon_pkg::bus_byte_t  add_in,
    output pseudo_random_sequence_gen_mon_pkg::bus_byte_t       add_out,
    input  wire pseudo_random_sequence_gen_mon_pkg::bus_byte_t  drop_in,
    input  wire logic [22:0]                  sig_in,
    input  wire logic                         restart_in,
    output logic [22:0]                       sig_out,
    output logic                              restart_out,
    output logic                              irq_out
);
    import pseudo_random_sequence_gen_mon_pkg::*;

    // ----------------------------------------------------------------
    // sequence step
    // ----------------------------------------------------------------
    // advance eight bits; returns new state, byte is the 8 feedback bits shifted in
    function automatic logic [30:0] pseudo_random_sequence_step(input logic [22:0] s);
        logic [22:0] st;
        logic [7:0]  b;
        logic        fb;
        st = s;
        b  = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            fb    = st[PSEUDO_RANDOM_SEQUENCE_LEN-1] ^ st[PSEUDO_RANDOM_SEQUENCE_TAP-1];
            b     = {b[6:0], fb};
            st    = {st[21:0], fb};
        end
        return {st, b};
    endfunction

    // true where the column carries no sequence data
    function automatic logic col_skip(input payload_t t, input logic [7:0] c);
        logic r;
        r = (c == 8'h01);
        case (t)
            PL_STS1:   r = r | (c == 8'h1E) | (c == 8'h3B);
            PL_STS12C: r = (c >= 8'h01) && (c <= 8'h04);
            PL_STS48C: r = (c >= 8'h01) && (c <= 8'h10);
            default:   r = r;
        endcase
        return r;
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [31:0]      ctrl_r, ctrl_nxt;
    logic [1:0]       int_stat_r, int_stat_nxt;
    logic [1:0]       int_mask_r, int_mask_nxt;
    logic [31:0]      rdata_r, rdata_nxt;
    logic [ERR_W-1:0] err_r, err_nxt;
    logic [22:0]      gen_r, gen_nxt;
    logic [22:0]      mon_r, mon_nxt;
    logic [7:0]       gcol_r, gcol_nxt;
    logic [7:0]       mcol_r, mcol_nxt;
    logic [5:0]       good_r, good_nxt;
    logic [4:0]       bad_r, bad_nxt;
    logic             locked_r, locked_nxt;
    logic             gen_oos_r, gen_oos_nxt;
    logic             mon_oos_r, mon_oos_nxt;
    bus_byte_t        add_r, add_nxt;
    logic [22:0]      sig_r, sig_nxt;
    logic             rst_r, rst_nxt;
    logic             irq_r, irq_nxt;

    typedef enum logic { HUNT, SYNC } mon_state_t;
    mon_state_t       mst_r, mst_nxt;

    payload_t         ptype;
    logic             gen_en, mon_en, own_frame, is_master, is_slave, restart;
    logic [30:0]      gstep, mstep;
    logic             g_slot, m_slot, match;
    logic [7:0]       gcol_cur, mcol_cur;

    assign ptype     = payload_t'(ctrl_r[CTRL_TYPE_LSB+:2]);
    assign gen_en    = ctrl_r[CTRL_GEN_EN];
    assign mon_en    = ctrl_r[CTRL_MON_EN];
    assign own_frame = ctrl_r[CTRL_OWN_FRAME];
    assign is_master = ctrl_r[CTRL_MASTER];
    assign is_slave  = ctrl_r[CTRL_SLAVE] & ~is_master;
    // a restart is a write of the restart bit in a master, or the master's strobe
    assign restart   = (reg_wr_in && reg_addr_in == ADDR_CTRL && reg_wdata_in[CTRL_RESTART]
                        && is_master)
                       | (is_slave & restart_in);
    assign gstep     = pseudo_random_sequence_step(gen_r);
    assign mstep     = pseudo_random_sequence_step(mon_r);
    // the byte carrying the frame marker is column 1 in that very cycle
    assign gcol_cur  = add_in.frame ? 8'h01 : gcol_r;
    assign mcol_cur  = drop_in.frame ? 8'h01 : mcol_r;

    // ----------------------------------------------------------------
    // generator
    // ----------------------------------------------------------------
    always_comb
    begin
        add_nxt     = add_in;
        gen_nxt     = gen_r;
        gcol_nxt    = gcol_cur;
        gen_oos_nxt = gen_oos_r;
        g_slot      = 1'b0;
        // own framing: every byte is payload and our overhead sits in column 1
        if (add_in.payload | own_frame)
        begin
            g_slot   = gen_en && (own_frame || !add_in.poh)
                       && !col_skip(ptype, gcol_cur);
            gcol_nxt = gcol_cur + 8'h01;
        end
        if (g_slot)
        begin
            add_nxt.data = gstep[7:0];
            add_nxt.payload = 1'b1;
            gen_nxt      = gstep[30:8];
        end
        // the transport frame marker is always kept; it is our column reference
        if (own_frame)
        begin
            add_nxt.payload = 1'b1;
            add_nxt.poh     = (gcol_cur == 8'h01);
        end
        // slaves compare against the master's broadcast, never adopt it
        if (is_slave && gen_en)
            gen_oos_nxt = (sig_in != gen_r);
        if (restart)
        begin
            gen_nxt     = PSEUDO_RANDOM_SEQUENCE_SEED;
            gen_oos_nxt = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // monitor
    // ----------------------------------------------------------------
    always_comb
    begin
        mon_nxt     = mon_r;
        mcol_nxt    = mcol_cur;
        good_nxt    = good_r;
        bad_nxt     = bad_r;
        mst_nxt     = mst_r;
        err_nxt     = err_r;
        mon_oos_nxt = mon_oos_r;
        m_slot      = 1'b0;
        match       = 1'b0;
        if (drop_in.payload)
        begin
            m_slot   = mon_en && !drop_in.poh && !col_skip(ptype, mcol_cur);
            mcol_nxt = mcol_cur + 8'h01;
        end
        if (m_slot)
        begin
            match = (drop_in.data == mstep[7:0]);
            case (mst_r)
                HUNT:
                begin
                    // self-seed from received bits while hunting
                    mon_nxt  = {mon_r[14:0], drop_in.data};
                    good_nxt = match ? good_r + 6'h01 : 6'h00;
                    if (match && good_r == 6'(LOCK_GOOD - 1))
                    begin
                        mst_nxt  = SYNC;
                        bad_nxt  = 5'h00;
                    end
                end
                SYNC:
                begin
                    mon_nxt = mstep[30:8];
                    bad_nxt = match ? 5'h00 : bad_r + 5'h01;
                    if (!match && err_r != {ERR_W{1'b1}})
                        err_nxt = err_r + 1'b1;
                    if (!match && bad_r == 5'(LOSS_BAD - 1))
                    begin
                        mst_nxt  = HUNT;
                        good_nxt = 6'h00;
                    end
                end
                default: mst_nxt = HUNT;
            endcase
        end
        if (is_slave && mon_en)
            mon_oos_nxt = (mst_r == SYNC) && (sig_in != mon_r);
        if (reg_wr_in && reg_addr_in == ADDR_CTRL && reg_wdata_in[CTRL_ERR_CLR])
            err_nxt = '0;
        if (!mon_en)
        begin
            mst_nxt  = HUNT;
            good_nxt = 6'h00;
        end
    end

    // ----------------------------------------------------------------
    // register port and interrupt
    // ----------------------------------------------------------------
    always_comb
    begin
        ctrl_nxt     = ctrl_r;
        int_mask_nxt = int_mask_r;
        int_stat_nxt = int_stat_r;
        rdata_nxt    = 32'h0000_0000;
        locked_nxt   = (mst_nxt == SYNC);
        // registering the next state keeps the signature level with slaves' own state
        sig_nxt      = is_master ? gen_nxt : 23'h00_0000;
        rst_nxt      = restart & is_master;
        if (reg_wr_in && reg_addr_in == ADDR_CTRL)
            ctrl_nxt = reg_wdata_in & ~(32'h1 << CTRL_RESTART) & ~(32'h1 << CTRL_ERR_CLR);
        if (reg_wr_in && reg_addr_in == ADDR_INT_MASK)
            int_mask_nxt = reg_wdata_in[1:0];
        if (reg_rd_in)
        begin
            case (reg_addr_in)
                ADDR_CTRL:     rdata_nxt = ctrl_r;
                ADDR_STATUS:   rdata_nxt = {29'h0, mon_oos_r, gen_oos_r, locked_r};
                ADDR_INT_STAT: rdata_nxt = {30'h0, int_stat_r};
                ADDR_INT_MASK: rdata_nxt = {30'h0, int_mask_r};
                ADDR_ERR_CNT:  rdata_nxt = 32'(err_r);
                default:       rdata_nxt = 32'h0000_0000;
            endcase
            if (reg_addr_in == ADDR_INT_STAT)
                int_stat_nxt = 2'b00;
        end
        // set wins over the read clear
        if (locked_nxt != locked_r)
            int_stat_nxt[INT_LOCK_CHG] = 1'b1;
        if ((gen_oos_nxt & ~gen_oos_r) | (mon_oos_nxt & ~mon_oos_r))
            int_stat_nxt[INT_OOS] = 1'b1;
        irq_nxt = |(int_stat_nxt & int_mask_r);
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_b_in)
        begin
            ctrl_r     <= CTRL_RESET;
            int_stat_r <= 2'b00;
            int_mask_r <= INT_MASK_RESET[1:0];
            rdata_r    <= 32'h0000_0000;
            err_r      <= '0;
            gen_r      <= PSEUDO_RANDOM_SEQUENCE_SEED;
            mon_r      <= PSEUDO_RANDOM_SEQUENCE_SEED;
            gcol_r     <= 8'h00;
            mcol_r     <= 8'h00;
            good_r     <= 6'h00;
            bad_r      <= 5'h00;
            locked_r   <= 1'b0;
            gen_oos_r  <= 1'b0;
            mon_oos_r  <= 1'b0;
            add_r      <= '0;
            sig_r      <= 23'h00_0000;
            rst_r      <= 1'b0;
            irq_r      <= 1'b0;
            mst_r      <= HUNT;
        end
        else
        begin
            ctrl_r     <= ctrl_nxt;
            int_stat_r <= int_stat_nxt;
            int_mask_r <= int_mask_nxt;
            rdata_r    <= rdata_nxt;
            err_r      <= err_nxt;
            gen_r      <= gen_nxt;
            mon_r      <= mon_nxt;
            gcol_r     <= gcol_nxt;
            mcol_r     <= mcol_nxt;
            good_r     <= good_nxt;
            bad_r      <= bad_nxt;
            locked_r   <= locked_nxt;
            gen_oos_r  <= gen_oos_nxt;
            mon_oos_r  <= mon_oos_nxt;
            add_r      <= add_nxt;
            sig_r      <= sig_nxt;
            rst_r      <= rst_nxt;
            irq_r      <= irq_nxt;
            mst_r      <= mst_nxt;
        end
    end

    assign reg_rdata_out = rdata_r;
    assign add_out       = add_r;
    assign sig_out       = sig_r;
    assign restart_out   = rst_r;
    assign irq_out       = irq_r;

endmodule

// *** verification/pseudo_random_sequence_gen_mon_monitor.sv ***
// port checker for the payload test-sequence block
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ns
module pseudo_random_sequence_gen_mon_monitor
    import pseudo_random_sequence_gen_mon_pkg::*;
#(
    parameter int ERR_W = 16
)
(
    input  wire logic                        clk_sys_in,
    input  wire logic                        rst_b_in,
    input  wire logic [3:0]                  reg_addr_in,
    input  wire logic [31:0]                 reg_wdata_in,
    input  wire logic                        reg_wr_in,
    input  wire logic                        reg_rd_in,
    input  wire logic [31:0]                 reg_rdata_out,
    input  wire pseudo_random_sequence_gen_mon_pkg::bus_byte_t add_in,
    input  wire pseudo_random_sequence_gen_mon_pkg::bus_byte_t add_out,
    input  wire pseudo_random_sequence_gen_mon_pkg::bus_byte_t drop_in,
    input  wire logic [22:0]                 sig_in,
    input  wire logic                        restart_in,
    input  wire logic [22:0]                 sig_out,
    input  wire logic                        restart_out,
    input  wire logic                        irq_out
);
    logic wr_restart;

    assign wr_restart = reg_wr_in && reg_addr_in == ADDR_CTRL && reg_wdata_in[CTRL_RESTART];

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_b_in);

    chk_rdata_quiet: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
        else $error("read data seen without a read");
    chk_unmapped_zero: assert property (reg_rd_in && reg_addr_in > ADDR_ERR_CNT
        |=> reg_rdata_out == 32'h0) else $error("unmapped read not zero");
    chk_err_width: assert property (reg_rd_in && reg_addr_in == ADDR_ERR_CNT
        |=> (reg_rdata_out >> ERR_W) == 32'h0) else $error("error count too wide");
    chk_status_width: assert property (reg_rd_in && reg_addr_in == ADDR_STATUS
        |=> reg_rdata_out[31:3] == 29'h0) else $error("status spare bits set");
    chk_poh_untouched: assert property (add_in.poh |=> add_out == $past(add_in))
        else $error("overhead byte altered");
    chk_restart_single: assert property (restart_out |=> !restart_out)
        else $error("restart pulse too long");
    chk_restart_cause: assert property ($rose(restart_out)
        |-> $past(wr_restart) || $past(wr_restart, 2)) else $error("restart without command");
    chk_irq_masked: assert property (reg_rd_in && reg_addr_in == ADDR_INT_MASK
        ##1 reg_rdata_out == 32'h0 |=> !irq_out) else $error("interrupt while all masked");
    chk_sig_slave_quiet: assert property (reg_rd_in && reg_addr_in == ADDR_CTRL
        ##1 !reg_rdata_out[CTRL_MASTER] |=> sig_out == 23'h0) else $error("signature from non-master");
endmodule

// *** verification/backplane_model.sv ***
// backplane model: frames the add bus and loops the add output onto the drop bus
// assumes it shares the block's byte clock; may flip one bit of chosen drop bytes
`timescale 1ns/1ns
module backplane_model
    import pseudo_random_sequence_gen_mon_pkg::*;
#(
    parameter int ROW_LEN = 90
)
(
    input  wire logic                        clk_in,
    input  wire logic                        rst_b_in,
    input  wire pseudo_random_sequence_gen_mon_pkg::bus_byte_t ret_in,
    input  wire logic                        gap_in,
    input  wire logic                        burst_go_in,
    input  wire logic [4:0]                  burst_len_in,
    output pseudo_random_sequence_gen_mon_pkg::bus_byte_t      add_bus_out,
    output pseudo_random_sequence_gen_mon_pkg::bus_byte_t      drop_bus_out
);
    logic [7:0] col_r;
    logic [7:0] col_nxt;
    logic [4:0] left_r;
    logic [4:0] left_nxt;
    logic       hit;

    always_comb
    begin
        col_nxt = (col_r == 8'(ROW_LEN - 1)) ? 8'h00 : col_r + 8'h01;
        // framing bytes are never hit, so with STS-3c payload every flip lands on a checked byte
        hit = left_r != 5'h00 && !ret_in.frame;
        left_nxt = burst_go_in ? burst_len_in : left_r - {4'h0, hit};
        // an optional gap after the framing byte shows whether payload markers are kept
        add_bus_out = '{data: 8'hA5, frame: col_r == 8'h00,
                        payload: !(gap_in && col_r == 8'h01), poh: col_r == 8'h00};
        drop_bus_out = ret_in;
        drop_bus_out.data = ret_in.data ^ {7'h00, hit};
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            col_r  <= 8'h00;
            left_r <= 5'h00;
        end
        else
        begin
            col_r  <= col_nxt;
            left_r <= left_nxt;
        end
    end
endmodule

// *** verification/pseudo_random_sequence_gen_mon_test.sv ***
// self-checking bench for the payload test-sequence block
// assumes the backplane model loops the add output back onto the drop bus
`timescale 1ns/1ns
module pseudo_random_sequence_gen_mon_test;
    import pseudo_random_sequence_gen_mon_pkg::*;
    localparam int ERR_W   = 4;
    localparam int ROW_LEN = 90;
    logic        clk_sys   = 1'h0;
    logic        rst_b     = 1'h0;
    logic [3:0]  reg_addr  = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'h0;
    logic        reg_rd    = 1'h0;
    logic [31:0] reg_rdata;
    bus_byte_t   add_in;
    bus_byte_t   add_out;
    bus_byte_t   drop_in;
    logic [22:0] sig_in    = 23'h0;
    logic        restart_in = 1'h0;
    logic        gap       = 1'h0;
    logic [22:0] sig_out;
    logic        restart_out;
    logic        irq;
    logic        burst_go  = 1'h0;
    logic [4:0]  burst_len = 5'h0;
    logic [31:0] v;
    int          fail_count = 0;
    int          tests_run  = 0;

    always #20 clk_sys = ~clk_sys;

    pseudo_random_sequence_gen_mon #(.ERR_W(ERR_W)) dut (.clk_sys_in(clk_sys), .rst_b_in(rst_b),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .add_in(add_in), .add_out(add_out),
        .drop_in(drop_in), .sig_in(sig_in), .restart_in(restart_in), .sig_out(sig_out),
        .restart_out(restart_out), .irq_out(irq));
    backplane_model #(.ROW_LEN(ROW_LEN)) far (.clk_in(clk_sys), .rst_b_in(rst_b),
        .ret_in(add_out), .gap_in(gap), .burst_go_in(burst_go), .burst_len_in(burst_len),
        .add_bus_out(add_in), .drop_bus_out(drop_in));

    // ----------------------------------------------------------------
    // bus and compare helpers
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic reset_dut();
        rst_b <= 1'h0;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'h1;
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'h1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_rd   <= 1'h1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1 v = reg_rdata;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_lock(input logic want);
        int n;
        n = 0;
        rd(ADDR_STATUS);
        while (v[ST_LOCKED] !== want && n < 100)
        begin
            rd(ADDR_STATUS);
            n++;
        end
        check("locked", {31'h0, want}, {31'h0, v[ST_LOCKED]});
    endtask
    task automatic corrupt(input logic [4:0] n);
        @(posedge clk_sys);
        burst_go  <= 1'h1;
        burst_len <= n;
        @(posedge clk_sys);
        burst_go <= 1'h0;
        tick(40);
    endtask
    function automatic logic skip_col(input int t, input int c);
        return c == 1 || (t == 2 && c <= 4) || (t == 3 && c <= 16) || (t == 0 && (c == 30 || c == 59));
    endfunction

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        rd(ADDR_CTRL);
        check("ctrl reset", CTRL_RESET, v);
        rd(ADDR_INT_MASK);
        check("mask reset", INT_MASK_RESET, v);
        wr(4'hF, 32'hFFFF_FFFF);
        rd(4'hF);
        check("unmapped", 32'h0, v);
    endtask
    task automatic t_columns();
        logic [7:0]  col [1:60];
        logic [31:0] w;
        logic        e1;
        logic        e2;
        int          n;
        for (int t = 0; t < 4; t++)
        begin
            wr(ADDR_CTRL, 32'h1 | 32'(t << CTRL_TYPE_LSB));
            tick(ROW_LEN);
            n = 0;
            while (add_out.frame !== 1'h1 && n < ROW_LEN)
            begin
                tick(1);
                n++;
            end
            check("frame found", 32'h1, {31'h0, add_out.frame});
            for (int c = 1; c <= 60; c++)
            begin
                col[c] = add_out.data;
                tick(1);
            end
            for (int c = 1; c <= 60; c++)
                if (skip_col(t, c))
                    check("skipped column", 32'hA5, {24'h0, col[c]});
            w = {col[17], col[18], col[19], col[20]};
            e1 = 1'h0;
            e2 = 1'h0;
            // accept either bit-numbering convention of the same polynomial
            for (int k = 23; k < 32; k++)
            begin
                e1 |= w[31 - k] ^ w[54 - k] ^ w[49 - k];
                e2 |= w[31 - k] ^ w[54 - k] ^ w[36 - k];
            end
            check("sequence taps", 32'h0, {31'h0, e1 & e2});
        end
    endtask
    task automatic t_framing();
        int n;
        gap <= 1'h1;
        for (int m = 0; m < 2; m++)
        begin
            wr(ADDR_CTRL, 32'h1 | 32'(m << CTRL_OWN_FRAME));
            tick(ROW_LEN);
            n = 0;
            while (add_out.frame !== 1'h1 && n < ROW_LEN)
            begin
                tick(1);
                n++;
            end
            tick(1);
            check("payload marker", 32'(m), {31'h0, add_out.payload});
        end
        gap <= 1'h0;
    endtask
    task automatic t_monitor();
        wr(ADDR_CTRL, 32'h42);
        tick(100);
        rd(ADDR_ERR_CNT);
        check("count unlocked", 32'h0, v);
        wr(ADDR_CTRL, 32'h43);
        wait_lock(1'h1);
        check("irq masked", 32'h0, {31'h0, irq});
        wr(ADDR_INT_MASK, 32'h1);
        tick(3);
        check("irq on", 32'h1, {31'h0, irq});
        rd(ADDR_INT_STAT);
        check("lock change", 32'h1, v);
        tick(3);
        check("irq off", 32'h0, {31'h0, irq});
        repeat (3) corrupt(5'h01);
        rd(ADDR_ERR_CNT);
        check("error count", 32'h3, v);
        corrupt(5'h10);
        rd(ADDR_INT_STAT);
        check("lock lost", 32'h1, v);
        wait_lock(1'h1);
        rd(ADDR_ERR_CNT);
        check("count saturated", 32'hF, v);
        wr(ADDR_CTRL, 32'h143);
        rd(ADDR_ERR_CNT);
        check("count cleared", 32'h0, v);
    endtask
    task automatic t_master();
        int n;
        reset_dut();
        wr(ADDR_CTRL, 32'hC9);
        tick(5);
        check("signature live", 32'h1, {31'h0, sig_out != 23'h0});
        wr(ADDR_CTRL, 32'hE9);
        // the pulse is launched by the edge that took the write
        tick(0);
        check("restart seed", 32'(PSEUDO_RANDOM_SEQUENCE_SEED), {9'h0, sig_out});
        n = 0;
        while (restart_out !== 1'h1 && n < 4)
        begin
            tick(1);
            n++;
        end
        check("restart pulse", 32'h1, {31'h0, restart_out});
        tick(1);
        check("restart single", 32'h0, {31'h0, restart_out});
    endtask
    task automatic t_slave();
        reset_dut();
        wr(ADDR_INT_MASK, 32'h2);
        sig_in <= 23'h000001;
        wr(ADDR_CTRL, 32'hD1);
        tick(50);
        rd(ADDR_STATUS);
        check("out of step", 32'h1, {31'h0, v[ST_GEN_OOS]});
        check("irq step", 32'h1, {31'h0, irq});
        tick(200);
        rd(ADDR_STATUS);
        check("no self realign", 32'h1, {31'h0, v[ST_GEN_OOS]});
        // generator off so the seed stands still after the master's restart
        wr(ADDR_CTRL, 32'hD0);
        @(posedge clk_sys);
        restart_in <= 1'h1;
        @(posedge clk_sys);
        restart_in <= 1'h0;
        tick(2);
        rd(ADDR_STATUS);
        check("restart realign", 32'h0, {31'h0, v[ST_GEN_OOS]});
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        reset_dut();
        t_regs();
        t_columns();
        t_framing();
        t_monitor();
        t_master();
        t_slave();
        print_verdict();
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        print_verdict();
    end
endmodule

bind pseudo_random_sequence_gen_mon pseudo_random_sequence_gen_mon_monitor #(.ERR_W(ERR_W)) chk_i (.clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .add_in(add_in), .add_out(add_out), .drop_in(drop_in), .sig_in(sig_in),
    .restart_in(restart_in), .sig_out(sig_out), .restart_out(restart_out), .irq_out(irq_out));
